// ### core/aeqsc_top.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "aeqsc_consts.svh"
module aeqsc_top import aeqsc_pkg::*; #(
	parameter logic [3:0] EQ_MAX = 4'hF
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic link_lock,
	input wire logic clk_bit_err,
	input wire logic sequence_check_err,
	input wire logic parity_err,
	output logic [3:0] eq_setting_ff,
	output logic [3:0] phase_setting_ff,
	output logic adapt_locked_ff
);
	logic [1:0] rst_sync_ff;
	logic rst_core_n;
	logic [3:0] upper_ff, lower_ff;
	logic [2:0] adapt_error_select_ff;
	logic phase_sweep_order_ff, two_step_validate_en_ff, loop_nesting_select_ff, phase_adapt_en_ff;
	logic [7:0] adapt_error_threshold_ff;
	logic [15:0] relock_timer_period_ff;
	logic start_ff, fail_ff;
	logic [1:0] lock_sync_ff;
	logic [2:0] err_s1_ff, err_s2_ff, err_s3_ff;
	logic [2:0] err_evt;
	aeqsc_state_t state_ff;
	logic [3:0] phase_left_ff;
	logic win_start;
	logic [15:0] win_len, half_len;
	logic win_expired, win_err_any;
	logic [8:0] win_count;
	logic [3:0] eff_upper, phase_first, phase_span;
	logic [31:0] ctl_word, limits_word;

	aeqsc_reg_if regs();

	// Reset release passes two flops; assertion stays asynchronous
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_core_n = rst_sync_ff[1];

	aeqsc_axil_slave u_bus (
		.clock(clock),
		.rst_n(rst_core_n),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.regs(regs)
	);

	// Link-side levels come from another domain, so two flops first
	always_ff @(posedge clock or negedge rst_core_n) begin
		if (!rst_core_n) begin
			lock_sync_ff <= 2'b00;
			err_s1_ff <= 3'h0;
			err_s2_ff <= 3'h0;
			err_s3_ff <= 3'h0;
		end else begin
			lock_sync_ff <= {lock_sync_ff[0], link_lock};
			err_s1_ff <= {clk_bit_err, sequence_check_err, parity_err};
			err_s2_ff <= err_s1_ff;
			err_s3_ff <= err_s2_ff;
		end
	end
	// One event per rising error level; a held level counts once
	assign err_evt = err_s2_ff & ~err_s3_ff;

	// A bad upper limit below the lower one is read as the lower one
	function automatic logic [3:0] clamp_phase(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
		if (v > hi) begin
			return hi;
		end
		if (v < lo) begin
			return lo;
		end
		return v;
	endfunction

	assign eff_upper = (upper_ff < lower_ff) ? lower_ff : upper_ff;
	assign phase_span = eff_upper - lower_ff;
	// Order 0 opens at the largest clock delay, order 1 at the midpoint
	assign phase_first = phase_sweep_order_ff ? clamp_phase(`AEQSC_PHASE_MID, lower_ff, eff_upper)
		: eff_upper;
	assign half_len = (relock_timer_period_ff >> 1) | 16'h0001;

	// Next phase in sweep order; order 1 wraps from upper to lower
	function automatic logic [3:0] next_phase(input logic [3:0] v, input logic ord, input logic [3:0] lo,
		input logic [3:0] hi);
		if (ord) begin
			return (v >= hi) ? lo : v + 4'h1;
		end
		return (v <= lo) ? hi : v - 4'h1;
	endfunction

	// Register writes; start is a self-clearing command bit
	always_ff @(posedge clock or negedge rst_core_n) begin
		if (!rst_core_n) begin
			upper_ff <= `AEQSC_UPPER_RST;
			lower_ff <= `AEQSC_LOWER_RST;
			adapt_error_select_ff <= `AEQSC_ERRSEL_RST;
			phase_sweep_order_ff <= 1'b0;
			two_step_validate_en_ff <= 1'b0;
			loop_nesting_select_ff <= 1'b0;
			phase_adapt_en_ff <= 1'b1;
			adapt_error_threshold_ff <= `AEQSC_THOLD_RST;
			relock_timer_period_ff <= `AEQSC_RELOCK_RST;
			start_ff <= 1'b0;
		end else begin
			start_ff <= 1'b0;
			if (regs.wr_stb && regs.wr_strb[0]) begin
				case (regs.wr_idx)
					`AEQSC_IDX_LIMITS: begin
						upper_ff <= regs.wr_data[`AEQSC_UPPER_MSB:`AEQSC_UPPER_LSB];
						lower_ff <= regs.wr_data[`AEQSC_LOWER_MSB:`AEQSC_LOWER_LSB];
					end
					`AEQSC_IDX_CTL: begin
						adapt_error_select_ff <= regs.wr_data[`AEQSC_ERRSEL_MSB:`AEQSC_ERRSEL_LSB];
						phase_sweep_order_ff <= regs.wr_data[`AEQSC_ORDER_BIT];
						two_step_validate_en_ff <= regs.wr_data[`AEQSC_TWOSTEP_BIT];
						loop_nesting_select_ff <= regs.wr_data[`AEQSC_NEST_BIT];
						phase_adapt_en_ff <= regs.wr_data[`AEQSC_PHASEEN_BIT];
					end
					`AEQSC_IDX_THOLD: adapt_error_threshold_ff <= regs.wr_data[7:0];
					`AEQSC_IDX_START: start_ff <= regs.wr_data[0];
					`AEQSC_IDX_RELOCK: relock_timer_period_ff[7:0] <= regs.wr_data[7:0];
					default: start_ff <= 1'b0; // Spare and status ignore writes
				endcase
			end
			if (regs.wr_stb && regs.wr_strb[1] && regs.wr_idx == `AEQSC_IDX_RELOCK) begin
				relock_timer_period_ff[15:8] <= regs.wr_data[15:8];
			end
		end
	end

	// Read mux; bit 7 of control and the spare register read zero
	assign ctl_word = {24'h0, 1'b0, adapt_error_select_ff, phase_sweep_order_ff, two_step_validate_en_ff,
		loop_nesting_select_ff, phase_adapt_en_ff};
	assign limits_word = {24'h0, upper_ff, lower_ff};
	always_comb begin
		regs.rd_hit = 1'b1;
		case (regs.rd_idx)
			`AEQSC_IDX_SPARE: regs.rd_data = 32'h00000000;
			`AEQSC_IDX_LIMITS: regs.rd_data = limits_word;
			`AEQSC_IDX_CTL: regs.rd_data = ctl_word;
			`AEQSC_IDX_THOLD: regs.rd_data = {24'h0, adapt_error_threshold_ff};
			`AEQSC_IDX_START: regs.rd_data = 32'h00000000;
			`AEQSC_IDX_RELOCK: regs.rd_data = {16'h0, relock_timer_period_ff};
			`AEQSC_IDX_STATUS: regs.rd_data = {20'h0, fail_ff, adapt_locked_ff, state_ff, phase_setting_ff,
				eq_setting_ff};
			default: begin
				regs.rd_data = 32'h00000000;
				regs.rd_hit = 1'b0;
			end
		endcase
	end
	assign regs.wr_hit = (regs.wr_idx >= `AEQSC_IDX_SPARE && regs.wr_idx <= `AEQSC_IDX_THOLD)
		|| (regs.wr_idx >= `AEQSC_IDX_START && regs.wr_idx <= `AEQSC_IDX_STATUS);

	// Window length: one-step settles a full period, everything else half
	// The window loads its length a cycle after the state has moved on
	always_comb begin
		win_len = half_len;
		if (state_ff == AEQSC_SETTLE && !two_step_validate_en_ff) begin
			win_len = relock_timer_period_ff;
		end
	end

	aeqsc_err_window #(.CNT_W(9)) u_win (
		.clock(clock),
		.rst_n(rst_core_n),
		.start(win_start),
		.length(win_len),
		.err_sel(adapt_error_select_ff),
		.err_evt(err_evt),
		.expired(win_expired),
		.err_any(win_err_any),
		.err_count(win_count)
	);

	// Adaptation engine: settle, optionally verify, then watch the link
	always_ff @(posedge clock or negedge rst_core_n) begin
		if (!rst_core_n) begin
			state_ff <= AEQSC_IDLE;
			eq_setting_ff <= 4'h0;
			phase_setting_ff <= `AEQSC_PHASE_MID;
			phase_left_ff <= 4'h0;
			adapt_locked_ff <= 1'b0;
			fail_ff <= 1'b0;
			win_start <= 1'b0;
		end else begin
			win_start <= 1'b0;
			if (start_ff) begin
				state_ff <= AEQSC_SETTLE;
				eq_setting_ff <= 4'h0;
				phase_setting_ff <= phase_adapt_en_ff ? phase_first
					: clamp_phase(`AEQSC_PHASE_MID, lower_ff, eff_upper);
				phase_left_ff <= phase_span;
				adapt_locked_ff <= 1'b0;
				fail_ff <= 1'b0;
				win_start <= 1'b1;
			end else begin
				case (state_ff)
					AEQSC_SETTLE: begin
						if (win_expired && two_step_validate_en_ff) begin
							state_ff <= AEQSC_VERIFY;
							win_start <= 1'b1;
						end else if (win_expired && lock_sync_ff[1]) begin
							state_ff <= AEQSC_MONITOR;
							adapt_locked_ff <= 1'b1;
							win_start <= 1'b1;
						end else if (win_expired) begin
							advance();
						end
					end
					AEQSC_VERIFY: begin
						if (win_err_any) begin
							advance();
						end else if (win_expired && lock_sync_ff[1]) begin
							state_ff <= AEQSC_MONITOR;
							adapt_locked_ff <= 1'b1;
							win_start <= 1'b1;
						end else if (win_expired) begin
							advance();
						end
					end
					AEQSC_MONITOR: begin
						if (win_expired && win_count > {1'b0, adapt_error_threshold_ff}
							&& eq_setting_ff < EQ_MAX) begin
							eq_setting_ff <= eq_setting_ff + 4'h1;
							adapt_locked_ff <= 1'b0;
							state_ff <= AEQSC_SETTLE;
							win_start <= 1'b1;
						end else if (win_expired) begin
							win_start <= 1'b1;
						end
					end
					default: state_ff <= AEQSC_IDLE;
				endcase
			end
		end
	end

	// Step to the next candidate; nesting picks which value moves first
	task automatic advance();
		win_start <= 1'b1;
		state_ff <= AEQSC_SETTLE;
		if (!phase_adapt_en_ff || !loop_nesting_select_ff) begin
			if (eq_setting_ff < EQ_MAX) begin
				eq_setting_ff <= eq_setting_ff + 4'h1;
			end else if (phase_adapt_en_ff && phase_left_ff != 4'h0) begin
				eq_setting_ff <= 4'h0;
				phase_setting_ff <= next_phase(phase_setting_ff, phase_sweep_order_ff, lower_ff, eff_upper);
				phase_left_ff <= phase_left_ff - 4'h1;
			end else begin
				state_ff <= AEQSC_IDLE;
				fail_ff <= 1'b1;
				win_start <= 1'b0;
			end
		end else if (phase_left_ff != 4'h0) begin
			phase_setting_ff <= next_phase(phase_setting_ff, phase_sweep_order_ff, lower_ff, eff_upper);
			phase_left_ff <= phase_left_ff - 4'h1;
		end else if (eq_setting_ff < EQ_MAX) begin
			phase_setting_ff <= phase_first;
			phase_left_ff <= phase_span;
			eq_setting_ff <= eq_setting_ff + 4'h1;
		end else begin
			state_ff <= AEQSC_IDLE;
			fail_ff <= 1'b1;
			win_start <= 1'b0;
		end
	endtask

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_core_n);

	chk_phase_upper_bound: assert property ((state_ff != AEQSC_IDLE && !start_ff && $stable(upper_ff)
		&& $stable(lower_ff)) |=> phase_setting_ff <= eff_upper)
		else $error("phase setting above upper limit");
	chk_phase_lower_bound: assert property ((state_ff != AEQSC_IDLE && !start_ff && $stable(upper_ff)
		&& $stable(lower_ff)) |=> phase_setting_ff >= lower_ff)
		else $error("phase setting below lower limit");
	chk_threshold_raise: assert property ((state_ff == AEQSC_MONITOR && win_expired && !start_ff
		&& win_count > {1'b0, adapt_error_threshold_ff} && eq_setting_ff < EQ_MAX)
		|=> eq_setting_ff == $past(eq_setting_ff) + 4'h1 && state_ff == AEQSC_SETTLE)
		else $error("threshold crossing did not raise equalizer");
	chk_sweep_start: assert property ((start_ff && phase_adapt_en_ff)
		|=> phase_setting_ff == $past(phase_first))
		else $error("sweep started at wrong phase");
	chk_one_step_judge: assert property ((state_ff == AEQSC_SETTLE && win_expired && !start_ff
		&& !two_step_validate_en_ff && lock_sync_ff[1]) |=> adapt_locked_ff && state_ff == AEQSC_MONITOR)
		else $error("one-step lock not accepted");
	chk_two_step_abort: assert property ((state_ff == AEQSC_VERIFY && win_err_any && !start_ff)
		|=> state_ff != AEQSC_MONITOR && !adapt_locked_ff)
		else $error("error in second step did not abort");
	chk_phase_held: assert property ((state_ff != AEQSC_IDLE && !phase_adapt_en_ff && !start_ff
		&& !$past(phase_adapt_en_ff)) |=> $stable(phase_setting_ff))
		else $error("phase moved while phase adaptation off");
	chk_phase_step: assert property ((state_ff != AEQSC_IDLE && !start_ff && $stable(lower_ff)
		&& $stable(upper_ff) && $stable(phase_sweep_order_ff)) |=> $stable(phase_setting_ff)
		|| phase_setting_ff == next_phase($past(phase_setting_ff), phase_sweep_order_ff, lower_ff, eff_upper)
		|| phase_setting_ff == phase_first)
		else $error("phase sweep skipped a value");
	chk_spare_reads_zero: assert property ((regs.rd_idx == `AEQSC_IDX_SPARE)
		|-> regs.rd_data == 32'h00000000 && ctl_word[7] == 1'b0)
		else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// ### core/aeqsc_consts.svh
`ifndef AEQSC_CONSTS_SVH
`define AEQSC_CONSTS_SVH
// Register indices; byte address is four times the index
`define AEQSC_IDX_SPARE 10'h040
`define AEQSC_IDX_LIMITS 10'h041
`define AEQSC_IDX_CTL 10'h042
`define AEQSC_IDX_THOLD 10'h043
`define AEQSC_IDX_START 10'h050
`define AEQSC_IDX_RELOCK 10'h051
`define AEQSC_IDX_STATUS 10'h052
// Field positions
`define AEQSC_UPPER_MSB 7
`define AEQSC_UPPER_LSB 4
`define AEQSC_LOWER_MSB 3
`define AEQSC_LOWER_LSB 0
`define AEQSC_ERRSEL_MSB 6
`define AEQSC_ERRSEL_LSB 4
`define AEQSC_ORDER_BIT 3
`define AEQSC_TWOSTEP_BIT 2
`define AEQSC_NEST_BIT 1
`define AEQSC_PHASEEN_BIT 0
// Reset values
`define AEQSC_UPPER_RST 4'hA
`define AEQSC_LOWER_RST 4'h9
`define AEQSC_ERRSEL_RST 3'h7
`define AEQSC_THOLD_RST 8'h01
`define AEQSC_RELOCK_RST 16'h0800
`define AEQSC_PHASE_MID 4'h7
`define AEQSC_RESP_OKAY 2'h0
`define AEQSC_RESP_SLVERR 2'h2
`endif

// ### core/aeqsc_pkg.sv
package aeqsc_pkg;
	// Adaptation engine states
	typedef enum logic [1:0] {
		AEQSC_IDLE = 2'b00,
		AEQSC_SETTLE = 2'b01,
		AEQSC_VERIFY = 2'b10,
		AEQSC_MONITOR = 2'b11
	} aeqsc_state_t;
	typedef logic [9:0] aeqsc_idx_t;
endpackage

// ### core/aeqsc_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
// Register access between the bus slave and the engine core
interface aeqsc_reg_if;
	logic wr_stb;
	logic [9:0] wr_idx;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;
	logic [9:0] rd_idx;
	logic [31:0] rd_data;
	logic rd_hit;
	modport bus (output wr_stb, output wr_idx, output wr_data, output wr_strb, output rd_idx,
		input wr_hit, input rd_data, input rd_hit);
	modport core (input wr_stb, input wr_idx, input wr_data, input wr_strb, input rd_idx,
		output wr_hit, output rd_data, output rd_hit);
endinterface
`default_nettype wire

// ### core/aeqsc_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "aeqsc_consts.svh"
module aeqsc_axil_slave import aeqsc_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	aeqsc_reg_if.bus regs
);
	logic aw_got_ff, w_got_ff;
	logic [9:0] aw_idx_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic do_write;

	// Write fires once both halves are held and no response is pending
	assign do_write = aw_got_ff && w_got_ff && !bvalid;
	assign regs.wr_stb = do_write;
	assign regs.wr_idx = aw_idx_ff;
	assign regs.wr_data = wdata_ff;
	assign regs.wr_strb = wstrb_ff;
	assign regs.rd_idx = araddr[11:2];

	// Address and data are taken independently, in either order
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_idx_ff <= 10'h000;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `AEQSC_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_got_ff <= 1'b1;
				aw_idx_ff <= awaddr[11:2];
				awready <= 1'b0;
			end else if (!aw_got_ff && !bvalid) begin
				awready <= 1'b1;
			end
			if (wvalid && wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
				wready <= 1'b0;
			end else if (!w_got_ff && !bvalid) begin
				wready <= 1'b1;
			end
			if (do_write) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid <= 1'b1;
				bresp <= regs.wr_hit ? `AEQSC_RESP_OKAY : `AEQSC_RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read data are captured at the address handshake, answered next cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `AEQSC_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= regs.rd_hit ? regs.rd_data : 32'h00000000;
			rresp <= regs.rd_hit ? `AEQSC_RESP_OKAY : `AEQSC_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### core/aeqsc_err_window.sv
`timescale 1ns/1ps
`default_nettype none
module aeqsc_err_window import aeqsc_pkg::*; #(
	parameter int CNT_W = 9
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [15:0] length,
	input wire logic [2:0] err_sel,
	input wire logic [2:0] err_evt,
	output logic expired,
	output logic err_any,
	output logic [CNT_W-1:0] err_count
);
	logic [15:0] left_ff;
	logic run_ff;
	logic [1:0] hits;

	// Only selected error kinds are counted; an all-zero select disables checking
	assign hits = 2'(err_evt[0] & err_sel[0]) + 2'(err_evt[1] & err_sel[1]) + 2'(err_evt[2] & err_sel[2]);
	assign err_any = run_ff && (hits != 2'h0);

	// Window timer; a zero length still lasts one cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			left_ff <= 16'h0000;
			run_ff <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start) begin
				left_ff <= (length == 16'h0000) ? 16'h0001 : length;
				run_ff <= 1'b1;
			end else if (run_ff) begin
				left_ff <= left_ff - 16'h0001;
				if (left_ff == 16'h0001) begin
					run_ff <= 1'b0;
					expired <= 1'b1;
				end
			end
		end
	end

	// Saturating error count over the running window
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_count <= '0;
		end else if (start) begin
			err_count <= '0;
		end else if (run_ff && err_count <= {CNT_W{1'b1}} - CNT_W'(3)) begin
			err_count <= err_count + CNT_W'(hits);
		end
	end

	chk_unselected_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		(err_sel == 3'h0) |=> (err_count == $past(err_count)) || $past(start))
		else $error("error counted with no kind selected");
endmodule
`default_nettype wire

// ### tb/tb_adaptive_eq_sweep_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "aeqsc_consts.svh"
module tb_adaptive_eq_sweep_control;
	localparam logic [1:0] ok = `AEQSC_RESP_OKAY;
	localparam logic [1:0] bad = `AEQSC_RESP_SLVERR;
	logic clock, rst_n, watch;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb, eq_setting_ff, phase_setting_ff;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, adapt_locked_ff;
	logic link_lock, clk_bit_err, sequence_check_err, parity_err;
	logic [15:0] seen;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed, lo, hi, k;

	aeqsc_top i_dut (.*);

	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Ceiling on cycles so a stuck handshake still ends the run
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end

	// Record visited phases and keep them inside the limits
	always @(posedge clock) begin
		if (watch) begin
			seen[phase_setting_ff] <= 1'b1;
			if (phase_setting_ff > hi || phase_setting_ff < lo) miss("phase out of limits");
		end
	end

	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic miss(input string m);
		mismatches++;
		$display("mismatch at %0t: %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared++;
		if (g !== e) miss(m);
	endtask

	// Write; both channels offered together, each dropped once taken
	task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
		logic a, w;
		a = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (a && s_axi_awready === 1'b1) begin
				a = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er, "write response");
		// Idle edge so bready is never assigned twice in one step
		@(posedge clock);
	endtask

	task automatic rd(input logic [9:0] idx);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rc(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er);
		rd(idx);
		chk(rv, e, "read data");
		chk(rr, er, "read response");
	endtask

	// One-cycle error pulses of one kind: 0 clock bit, 1 sequence, 2 parity
	task automatic pulse(input int t, input int n);
		repeat (n) begin
			{clk_bit_err, sequence_check_err, parity_err} <= 3'h4 >> t;
			@(posedge clock);
			{clk_bit_err, sequence_check_err, parity_err} <= 3'h0;
			@(posedge clock);
		end
	endtask

	task automatic wait_lock(input int n);
		repeat (n) begin
			@(posedge clock);
			if (adapt_locked_ff === 1'b1) break;
		end
	endtask

	initial begin
		seed = 44833;
		{rst_n, watch, link_lock, clk_bit_err, sequence_check_err, parity_err} = 6'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		lo = 0;
		hi = 15;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		// Reset values, reserved places and an unmapped index
		rc(`AEQSC_IDX_LIMITS, 32'h000000A9, ok);
		rc(`AEQSC_IDX_CTL, 32'h00000071, ok);
		rc(`AEQSC_IDX_THOLD, 32'h00000001, ok);
		wr(`AEQSC_IDX_SPARE, 32'h000000FF, ok);
		rc(`AEQSC_IDX_SPARE, 32'h00000000, ok);
		wr(`AEQSC_IDX_CTL, 32'h000000FF, ok);
		rc(`AEQSC_IDX_CTL, 32'h0000007F, ok);
		wr(10'h3FF, 32'h0000005A, bad);
		rc(10'h3FF, 32'h00000000, bad);
		// Random legal limit pairs read back whole
		repeat (6) begin
			lo = {$random(seed)} % 15;
			hi = lo + {$random(seed)} % (15 - lo);
			wr(`AEQSC_IDX_LIMITS, {24'h0, hi[3:0], lo[3:0]}, ok);
			rc(`AEQSC_IDX_LIMITS, {24'h0, hi[3:0], lo[3:0]}, ok);
		end
		// Short relock period keeps each sweep under two thousand cycles
		wr(`AEQSC_IDX_RELOCK, 32'h00000010, ok);
		// Sweeps with no lock: order 0 nest 0, then order 1 nest 1
		for (k = 0; k < 2; k++) begin
			lo = k ? 4 : {$random(seed)} % 10;
			hi = k ? 9 : lo + {$random(seed)} % 5;
			wr(`AEQSC_IDX_LIMITS, {24'h0, hi[3:0], lo[3:0]}, ok);
			wr(`AEQSC_IDX_CTL, k ? 32'h0000007B : 32'h00000071, ok);
			seen <= 16'h0000;
			wr(`AEQSC_IDX_START, 32'h00000001, ok);
			repeat (4) @(posedge clock);
			chk(phase_setting_ff, k ? 7 : hi, "sweep start");
			watch <= 1'b1;
			repeat (41) @(posedge clock);
			chk(eq_setting_ff == 4'h0, k, "inner loop");
			chk(phase_setting_ff == (k ? 7 : hi), !k, "outer loop");
			repeat (800) begin
				rd(`AEQSC_IDX_STATUS);
				if (rv[11] === 1'b1) break;
			end
			watch <= 1'b0;
			chk(rv[11], 1, "sweep exhausted");
			chk(seen, ((32'h1 << (hi + 1)) - 1) ^ ((32'h1 << lo) - 1), "phases visited");
		end
		// Locked link, phase off, one error kind selected at a time
		wr(`AEQSC_IDX_LIMITS, 32'h000000B3, ok);
		link_lock <= 1'b1;
		for (k = 0; k < 3; k++) begin
			wr(`AEQSC_IDX_CTL, {25'h0, 3'h4 >> k, 4'h0}, ok);
			wr(`AEQSC_IDX_START, 32'h00000001, ok);
			// Still unlocked well past half the period: one-step waits it all
			repeat (14) @(posedge clock);
			chk(adapt_locked_ff, 1'b0, "early lock");
			wait_lock(80);
			chk(adapt_locked_ff, 1'b1, "lock after wait");
			chk(phase_setting_ff, 4'h7, "phase held");
			pulse((k + 1) % 3, 3);
			pulse((k + 2) % 3, 3);
			repeat (30) @(posedge clock);
			chk(eq_setting_ff, 4'h0, "unselected errors");
			// Four events so that one window always holds two, whatever the phase
			pulse(k, 4);
			repeat (40) begin
				@(posedge clock);
				if (eq_setting_ff !== 4'h0) break;
			end
			chk(eq_setting_ff, 4'h1, "raise over threshold");
		end
		// Two-step: errors in the check half move on unless none selected
		for (k = 0; k < 2; k++) begin
			wr(`AEQSC_IDX_CTL, k ? 32'h00000004 : 32'h00000074, ok);
			wr(`AEQSC_IDX_START, 32'h00000001, ok);
			repeat (20) pulse({$random(seed)} % 3, 1);
			chk(eq_setting_ff == 4'h0, k, "two-step advance");
			wait_lock(80);
			chk(adapt_locked_ff, 1'b1, "two-step lock");
		end
		end_sim();
	end
endmodule
`default_nettype wire
